// *** src/host_bridge.sv ***
`timescale 1ns/1ps
`include "hbridge_map.svh"
// How it works
// - Shared-memory strap sampled at reset; low enables
// - Host command requests core bus, then transfers
// - Channel ready held low during shared access
// - Completion needs active mode, enable, shadow-off
// - Reset-mode strap low: wait until completable
// - Reset-mode strap high: assert host reset
// - No memory cycle for a resetting access
// - Address bit zero selects memory byte lane
// - Writes buffered, issued after host strobe ends
// - Core index/data are the host RTC pair
// - Lock clear: core RTC access blocked
// - Lock set: host RTC access blocked
// - Unlock request clears RTC internal locks
// - Legacy addresses; strap high forces the enables on
// - Config base decoded only once valid set
// - Config lock freezes base; only power-up reset clears
// - Full 16-bit decode, KBC/PM/RTC select only if enabled
// - Bit 0 picks RTC reg, bit 2 KBC/PM reg
// - RTC index 0070h, data 0071h
// - PM channel at 0062h and 0066h
module host_bridge (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic power_up_rst,
	input wire logic shared_memory_strap_n,
	input wire logic host_reset_mode_strap,
	input wire logic device_enable_strap,
	input wire logic active_mode,
	input wire logic shared_mem_enable_bit,
	input wire logic shadow_disable_bit,
	input wire logic host_mem_read_n,
	input wire logic host_mem_write_n,
	input wire logic host_mem_select_n,
	input wire logic host_addr_enable_n,
	input wire logic host_io_read_n,
	input wire logic host_io_write_n,
	input wire logic [18:0] host_address_bus,
	input wire logic [7:0] host_data_in,
	output logic [7:0] host_data_out,
	output logic host_data_oe,
	output logic host_channel_ready,
	output logic host_reset_out_n,
	output logic shared_mem_on,
	output logic core_bus_req,
	input wire logic core_bus_grant,
	input wire logic core_cycle_busy,
	output logic [18:0] mem_addr,
	output logic [15:0] mem_wdata,
	output logic [1:0] mem_byte_en,
	output hbridge_pkg::mem_cmd_t mem_cmd,
	input wire logic [15:0] mem_rdata,
	input wire logic mem_done,
	input wire logic [3:0] dev_enable,
	output hbridge_pkg::dev_sel_t dev_sel,
	output logic dev_reg_sel,
	input wire logic [7:0] cfg_base_addr_high,
	input wire logic [7:0] cfg_base_addr_low,
	input wire logic cfg_base_valid_bit,
	input wire logic cfg_lock_set,
	output logic cfg_lock_bit,
	output logic [15:0] cfg_base_r,
	output logic cfg_valid_r,
	input wire logic rtc_core_lock_bit,
	input wire logic rtc_unlock_request_bit,
	output logic rtc_clear_locks,
	input wire logic core_rtc_wr,
	input wire logic core_rtc_is_data,
	input wire logic [7:0] core_rtc_wdata,
	output logic [7:0] rtc_core_data_reg,
	output logic [7:0] rtc_core_index_reg,
	input wire logic [7:0] rtc_rdata,
	output logic rtc_wr,
	output logic [7:0] rtc_wdata
);
	typedef enum logic [2:0] {
		M_IDLE, M_WAIT, M_REQ, M_READ, M_HOLD, M_WPEND, M_RESET
	} mem_state_t;
	mem_state_t st_r, st_nxt;
	// Two-flop synchronisers for the host strobe pins only; address and data are not synchronised
	logic [6:0] s1_r, s2_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_r <= 7'h7f;
			s2_r <= 7'h7f;
		end else begin
			s1_r <= {host_mem_read_n, host_mem_write_n, host_mem_select_n,
				host_addr_enable_n, host_io_read_n, host_io_write_n, 1'b1};
			s2_r <= s1_r;
		end
	end
	wire mrd = !s2_r[6] && !s2_r[4];
	wire mwr = !s2_r[5] && !s2_r[4];
	wire strobes_high = s2_r[6] && s2_r[5];
	wire io_cyc = !s2_r[3];
	wire iord = io_cyc && !s2_r[2];
	wire iowr = io_cyc && !s2_r[1];
	logic iord_q_r, iowr_q_r;
	// Straps caught on the first clock after rst release
	logic strap_done_r, share_r, rmode_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			strap_done_r <= 1'b0;
			share_r <= 1'b0;
			rmode_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_done_r <= 1'b1;
			share_r <= !shared_memory_strap_n;
			rmode_r <= host_reset_mode_strap;
		end
	end
	assign shared_mem_on = share_r;
	wire can_finish = strap_done_r && active_mode && shared_mem_enable_bit
		&& shadow_disable_bit;
	wire mem_cmd_seen = share_r && (mrd || mwr);
	// RTC read data reaches the host one cycle late, so it is fresh by the second strobe cycle
	wire [7:0] host_rtc_rd;
	wire [7:0] io_rdata = dev_sel.rtc ? host_rtc_rd : 8'hff;
	logic is_wr_r, completed_r;
	logic [18:0] addr_r;
	logic [7:0] wbuf_r;
	function automatic logic [15:0] lane_place(input logic [7:0] b, input logic hi);
		lane_place = hi ? {b, 8'h00} : {8'h00, b};
	endfunction : lane_place
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			M_IDLE: if (mem_cmd_seen) st_nxt = M_WAIT;
			M_WAIT: if (can_finish) st_nxt = M_REQ;
				else if (rmode_r) st_nxt = M_RESET;
			M_REQ: if (core_bus_grant && !core_cycle_busy)
				st_nxt = is_wr_r ? M_HOLD : M_READ;
			M_READ: if (mem_done) st_nxt = M_HOLD;
			M_HOLD: if (strobes_high) st_nxt = is_wr_r ? M_WPEND : M_IDLE;
			M_WPEND: if (mem_done) st_nxt = M_IDLE;
			M_RESET: if (strobes_high && completed_r) st_nxt = M_IDLE;
		endcase
	end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			st_r <= M_IDLE;
			is_wr_r <= 1'b0;
			addr_r <= 19'h00000;
			wbuf_r <= 8'h00;
			host_data_out <= 8'h00;
			completed_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			if (st_r == M_IDLE && mem_cmd_seen) begin
				is_wr_r <= mwr;
				addr_r <= host_address_bus;
			end
			if (st_r != M_IDLE && st_r != M_WPEND && mwr)
				wbuf_r <= host_data_in;
			if (st_r == M_READ && mem_done)
				host_data_out <= addr_r[`ADDR_LSB_POS] ? mem_rdata[15:8] : mem_rdata[7:0];
			else if (iord && iord_q_r)
				host_data_out <= io_rdata;
			if (st_r == M_RESET && !strobes_high)
				completed_r <= 1'b1;
			else if (st_r != M_RESET)
				completed_r <= 1'b0;
		end
	end
	assign host_channel_ready = !(st_r == M_WAIT || st_r == M_REQ || st_r == M_READ);
	assign host_reset_out_n = (st_r != M_RESET);
	assign core_bus_req = (st_r == M_REQ || st_r == M_READ || st_r == M_WPEND);
	assign mem_addr = addr_r;
	assign mem_wdata = lane_place(wbuf_r, addr_r[`ADDR_LSB_POS]);
	assign mem_byte_en = addr_r[`ADDR_LSB_POS] ? 2'b10 : 2'b01;
	assign mem_cmd.read_n = (st_r != M_READ);
	// Buffered write waits for its own grant; the core may have taken the bus meanwhile
	wire wr_go = (st_r == M_WPEND) && core_bus_grant && !core_cycle_busy;
	assign mem_cmd.write_n = !wr_go;
	assign mem_cmd.select_n = !(st_r == M_READ || wr_go);
	// Config base and lock; lock only drops on power-up reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cfg_base_r <= `CFG_BASE_RST;
			cfg_valid_r <= 1'b0;
		end else if (!cfg_lock_bit) begin
			cfg_base_r <= {cfg_base_addr_high, cfg_base_addr_low};
			cfg_valid_r <= cfg_base_valid_bit;
		end
	end
	always_ff @(posedge core_clk or posedge power_up_rst) begin
		if (power_up_rst)
			cfg_lock_bit <= 1'b0;
		else if (cfg_lock_set)
			cfg_lock_bit <= 1'b1;
	end
	// Strap high keeps all enables forced on until reset; firmware can only add enables
	logic en_init_r;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			en_init_r <= 1'b0;
		else if (!strap_done_r)
			en_init_r <= device_enable_strap;
	end
	wire [3:0] en = dev_enable | {4{en_init_r}};
	wire [15:0] ha = host_address_bus[15:0];
	wire [15:0] ha_kp = ha & ~(16'h0001 << `ADDR_BIT_TWO_POS);
	wire hit_kbc = (ha_kp == `KBC_DATA_ADDR) && en[3];
	wire hit_pm = (ha_kp == `PM_DATA_ADDR) && en[2];
	wire hit_rtc = ((ha & ~`CFG_PORT_SPAN) == `RTC_INDEX_ADDR) && en[1];
	wire hit_cfg = cfg_valid_r && ((ha & ~`CFG_PORT_SPAN) == cfg_base_r);
	assign dev_sel = '{kbc: io_cyc && hit_kbc, pm: io_cyc && hit_pm,
		rtc: io_cyc && hit_rtc, cfg: io_cyc && hit_cfg};
	assign dev_reg_sel = dev_sel.rtc || dev_sel.cfg ? ha[`ADDR_LSB_POS]
		: ha[`ADDR_BIT_TWO_POS];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			iord_q_r <= 1'b0;
			iowr_q_r <= 1'b0;
		end else begin
			iord_q_r <= iord;
			iowr_q_r <= iowr;
		end
	end
	assign host_data_oe = (mrd && share_r) || (iord && dev_sel != '0);
	assign rtc_clear_locks = rtc_unlock_request_bit;
	rtc_port u_rtc (
		.core_clk(core_clk),
		.rst(rst),
		.core_lock(rtc_core_lock_bit),
		.host_wr(iowr && !iowr_q_r && dev_sel.rtc),
		.host_rd(iord && dev_sel.rtc),
		.host_is_data(ha[`ADDR_LSB_POS]),
		.host_wdata(host_data_in),
		.core_wr(core_rtc_wr),
		.core_is_data(core_rtc_is_data),
		.core_wdata(core_rtc_wdata),
		.rtc_rdata(rtc_rdata),
		.index_r(rtc_core_index_reg),
		.rtc_wr(rtc_wr),
		.rtc_wdata_r(rtc_wdata),
		.host_rdata_r(host_rtc_rd),
		.core_rdata_r(rtc_core_data_reg)
	);
	ready_low_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r == M_WAIT && !can_finish && !rmode_r) |=> !host_channel_ready)
		else $error("channel ready released early");
	reset_no_cycle_a: assert property (@(posedge core_clk) disable iff (rst)
		!host_reset_out_n |-> mem_cmd.select_n)
		else $error("memory cycle during host reset");
	reset_enter_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r == M_WAIT && !can_finish && rmode_r) |=> !host_reset_out_n)
		else $error("host reset not raised");
	write_after_a: assert property (@(posedge core_clk) disable iff (rst)
		!mem_cmd.write_n |-> $past(strobes_high, 1) || $past(!mem_cmd.write_n))
		else $error("write issued before host cycle end");
	lane_pick_a: assert property (@(posedge core_clk) disable iff (rst)
		!mem_cmd.write_n |-> mem_byte_en == (mem_addr[0] ? 2'b10 : 2'b01))
		else $error("wrong byte lane");
	grant_wait_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r == M_REQ && core_cycle_busy) |=> st_r == M_REQ)
		else $error("host took bus over core cycle");
	lock_sticky_a: assert property (@(posedge core_clk) disable iff (power_up_rst)
		cfg_lock_bit |=> cfg_lock_bit)
		else $error("config lock dropped");
	cfg_frozen_a: assert property (@(posedge core_clk) disable iff (rst)
		$past(cfg_lock_bit) && cfg_lock_bit |-> $stable(cfg_base_r))
		else $error("config base changed while locked");
	cmd_stretch_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r == M_IDLE && mem_cmd_seen) |=> !host_channel_ready)
		else $error("access not stretched");
	finish_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		(st_r == M_WAIT && !can_finish) |=> st_r != M_REQ)
		else $error("access went ahead before completion allowed");
	write_owned_a: assert property (@(posedge core_clk) disable iff (rst)
		!mem_cmd.write_n |-> core_bus_req && core_bus_grant)
		else $error("memory write without bus ownership");
	strap_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(strap_done_r && $past(strap_done_r)) |-> $stable(share_r) && $stable(rmode_r))
		else $error("strap result changed after reset");
	cfg_hidden_a: assert property (@(posedge core_clk) disable iff (rst)
		!cfg_valid_r |-> !dev_sel.cfg)
		else $error("config port decoded before valid");
	lane_data_a: assert property (@(posedge core_clk) disable iff (rst)
		!mem_cmd.write_n |-> wbuf_r == (mem_addr[0] ? mem_wdata[15:8] : mem_wdata[7:0]))
		else $error("write byte on wrong lane");
	reset_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		(!host_reset_out_n && !strobes_high) |=> !host_reset_out_n)
		else $error("host reset released during strobe");
	ready_cover_c: cover property (@(posedge core_clk) disable iff (rst)
		st_r == M_READ ##1 st_r == M_HOLD);
	wpend_cover_c: cover property (@(posedge core_clk) disable iff (rst)
		st_r == M_WPEND);
	reset_cover_c: cover property (@(posedge core_clk) disable iff (rst)
		!host_reset_out_n ##1 host_reset_out_n);
	busy_cover_c: cover property (@(posedge core_clk) disable iff (rst)
		st_r == M_REQ && core_bus_grant && core_cycle_busy);
	held_cover_c: cover property (@(posedge core_clk) disable iff (rst)
		st_r == M_WAIT && !can_finish ##1 st_r == M_REQ);
endmodule : host_bridge

// *** src/hbridge_map.svh ***
`ifndef HBRIDGE_MAP_SVH
`define HBRIDGE_MAP_SVH
`define KBC_DATA_ADDR 16'h0060
`define KBC_CMD_ADDR 16'h0064
`define PM_DATA_ADDR 16'h0062
`define PM_CMD_ADDR 16'h0066
`define RTC_INDEX_ADDR 16'h0070
`define RTC_DATA_ADDR 16'h0071
`define ADDR_LSB_POS 0
`define ADDR_BIT_TWO_POS 2
`define CFG_PORT_SPAN 16'h0001
`define RTC_INDEX_RST 8'h00
`define CFG_BASE_RST 16'h0000
`endif

// *** src/hbridge_pkg.sv ***
package hbridge_pkg;
	typedef struct packed {
		logic read_n;
		logic write_n;
		logic select_n;
	} mem_cmd_t;
	typedef struct packed {
		logic kbc;
		logic pm;
		logic rtc;
		logic cfg;
	} dev_sel_t;
	typedef enum logic [1:0] {
		CORE_IDLE,
		CORE_BUSY
	} core_state_t;
endpackage : hbridge_pkg

// *** src/rtc_port.sv ***
`timescale 1ns/1ps
`include "hbridge_map.svh"
// Index/data pair shared by host and core; owner chosen by the lock bit.
module rtc_port (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic core_lock,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic host_is_data,
	input wire logic [7:0] host_wdata,
	input wire logic core_wr,
	input wire logic core_is_data,
	input wire logic [7:0] core_wdata,
	input wire logic [7:0] rtc_rdata,
	output logic [7:0] index_r,
	output logic rtc_wr,
	output logic [7:0] rtc_wdata_r,
	output logic [7:0] host_rdata_r,
	output logic [7:0] core_rdata_r
);
	wire host_ok = !core_lock;
	wire w_host = host_wr && host_ok;
	wire w_core = core_wr && core_lock;
	wire wr_is_data = w_host ? host_is_data : core_is_data;
	wire [7:0] wr_val = w_host ? host_wdata : core_wdata;
	wire [7:0] rd_val = host_is_data ? rtc_rdata : index_r;
	logic rtc_wr_nxt;
	assign rtc_wr_nxt = (w_host || w_core) && wr_is_data;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			index_r <= `RTC_INDEX_RST;
			rtc_wr <= 1'b0;
			rtc_wdata_r <= 8'h00;
			host_rdata_r <= 8'h00;
			core_rdata_r <= 8'h00;
		end else begin
			rtc_wr <= rtc_wr_nxt;
			if ((w_host || w_core) && !wr_is_data)
				index_r <= wr_val;
			if (w_host || w_core)
				rtc_wdata_r <= wr_val;
			if (host_rd && host_ok)
				host_rdata_r <= rd_val;
			core_rdata_r <= core_lock ? (core_is_data ? rtc_rdata : index_r) : 8'hff;
		end
	end
	core_wr_blocked_a: assert property (@(posedge core_clk) disable iff (rst)
		(core_wr && !core_lock && !host_wr) |=> !rtc_wr && $stable(index_r))
		else $error("blocked core write reached rtc");
	host_wr_blocked_a: assert property (@(posedge core_clk) disable iff (rst)
		(host_wr && core_lock && !core_wr) |=> !rtc_wr && $stable(index_r))
		else $error("blocked host write reached rtc");
endmodule : rtc_port

// *** verif/mem_partner.sv ***
`timescale 1ns/1ps
// Core bus arbiter plus memory behind the bridge; slow stretches both waits.
module mem_partner (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic host_wr_low,
	input wire logic core_bus_req,
	input wire hbridge_pkg::mem_cmd_t mem_cmd,
	input wire logic [18:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [1:0] mem_byte_en,
	output logic core_bus_grant,
	output logic core_cycle_busy,
	output logic [15:0] mem_rdata,
	output logic mem_done,
	output logic [15:0] wdata_seen,
	output logic [1:0] be_seen,
	output int n_cycles,
	output logic early_write
);
	logic [3:0] arb_r;
	logic [3:0] acc_r;
	logic served_r;
	wire logic cyc_on = !mem_cmd.select_n && (!mem_cmd.read_n || !mem_cmd.write_n);
	// In fast mode the grant arrives while a core cycle is still finishing
	assign core_cycle_busy = core_bus_req && arb_r < 4'h4;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			{arb_r, acc_r, served_r, core_bus_grant, mem_done} <= '0;
			mem_rdata <= 16'h0000;
			wdata_seen <= 16'h0000;
			be_seen <= 2'h0;
			n_cycles <= 0;
			early_write <= 1'b0;
		end else begin
			mem_done <= 1'b0;
			// Released data bus never holds the last value
			mem_rdata <= ~mem_rdata;
			arb_r <= !core_bus_req ? 4'h0 : (arb_r == 4'hf ? arb_r : arb_r + 4'h1);
			core_bus_grant <= core_bus_req && (core_bus_grant || arb_r >= (slow ? 4'h6 : 4'h2));
			acc_r <= (cyc_on && !served_r) ? acc_r + 4'h1 : 4'h0;
			if (!core_bus_req) begin
				served_r <= 1'b0;
			end
			if (cyc_on && !served_r && acc_r >= (slow ? 4'h5 : 4'h1)) begin
				mem_done <= 1'b1;
				served_r <= 1'b1;
				n_cycles <= n_cycles + 1;
				mem_rdata <= {mem_addr[7:0] ^ 8'ha5, mem_addr[7:0] ^ 8'h3c};
				wdata_seen <= mem_wdata;
				be_seen <= mem_byte_en;
			end
			if (!mem_cmd.write_n && !mem_cmd.select_n && host_wr_low) begin
				early_write <= 1'b1;
			end
		end
	end
endmodule : mem_partner

// *** verif/host_bridge_tb.sv ***
`timescale 1ns/1ps
module host_bridge_tb;
	logic core_clk = 1'b0, rst = 1'b1, power_up_rst = 1'b1, slow = 1'b0;
	logic shared_memory_strap_n = 1'b0, host_reset_mode_strap = 1'b0, device_enable_strap = 1'b0;
	logic active_mode = 1'b1, shared_mem_enable_bit = 1'b1, shadow_disable_bit = 1'b1;
	logic host_mem_read_n = 1'b1, host_mem_write_n = 1'b1, host_mem_select_n = 1'b1;
	logic host_addr_enable_n = 1'b1, host_io_read_n = 1'b1, host_io_write_n = 1'b1;
	logic [18:0] host_address_bus = 19'h00000;
	logic [18:0] mem_addr;
	logic [7:0] host_data_in = 8'h00, cfg_base_addr_high = 8'h00, cfg_base_addr_low = 8'h00;
	logic [7:0] core_rtc_wdata = 8'h00, rtc_rdata = 8'h00, host_data_out, rtc_core_data_reg;
	logic [7:0] rtc_core_index_reg, rtc_wdata;
	logic [3:0] dev_enable = 4'h0;
	logic cfg_base_valid_bit = 1'b0, cfg_lock_set = 1'b0, rtc_core_lock_bit = 1'b0;
	logic rtc_unlock_request_bit = 1'b0, core_rtc_wr = 1'b0, core_rtc_is_data = 1'b0;
	logic host_data_oe, host_channel_ready, host_reset_out_n, shared_mem_on, core_bus_req;
	logic core_bus_grant, core_cycle_busy, mem_done, dev_reg_sel, cfg_lock_bit, cfg_valid_r;
	logic rtc_clear_locks, rtc_wr, early_write, wr_seen;
	logic [15:0] mem_wdata, mem_rdata, cfg_base_r, wdata_seen;
	logic [1:0] mem_byte_en, be_seen;
	hbridge_pkg::mem_cmd_t mem_cmd;
	hbridge_pkg::dev_sel_t dev_sel;
	int bad_count = 0, n_tests = 0, n_cycles, cyc = 0, base;
	wire logic host_wr_low = !host_mem_write_n;
	host_bridge dut (.*);
	mem_partner u_mem (.*);
	initial forever #2 core_clk = ~core_clk;
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic rst_go;
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		tick(2);
	endtask : rst_go
	task automatic wait_ready(input logic lvl, input int max);
		for (int i = 0; i < max && host_channel_ready !== lvl; i++) tick(1);
		chk("ready", {31'h0, lvl}, {31'h0, host_channel_ready});
	endtask : wait_ready
	task automatic mem_go(input logic wr, input logic [18:0] a, input logic [7:0] d);
		host_address_bus = a;
		host_data_in = d;
		host_mem_select_n = 1'b0;
		host_mem_read_n = wr;
		host_mem_write_n = !wr;
		tick(1);
	endtask : mem_go
	task automatic mem_stop;
		{host_mem_read_n, host_mem_write_n, host_mem_select_n} = 3'h7;
		tick(4);
	endtask : mem_stop
	task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d);
		host_address_bus = {3'h0, a};
		host_data_in = d;
		host_addr_enable_n = 1'b0;
		host_io_write_n = !wr;
		host_io_read_n = wr;
		tick(5);
	endtask : io
	task automatic io_end;
		{host_addr_enable_n, host_io_read_n, host_io_write_n} = 3'h7;
		tick(3);
	endtask : io_end
	task automatic core_wr(input logic is_data, input logic [7:0] d);
		core_rtc_is_data = is_data;
		core_rtc_wdata = d;
		core_rtc_wr = 1'b1;
		tick(1);
		wr_seen = rtc_wr;
		core_rtc_wr = 1'b0;
		tick(2);
	endtask : core_wr
	task automatic s_mem;
		chk("idle", 32'h7e, {host_channel_ready, host_reset_out_n, mem_cmd, shared_mem_on,
			core_bus_req});
		mem_go(1'b0, 19'h12345, 8'h00);
		wait_ready(1'b0, 10);
		wait_ready(1'b1, 100);
		chk("rdata", 32'he0, {24'h0, host_data_out});
		chk("rlane", 32'h2, {30'h0, be_seen});
		chk("maddr", 32'h12345, {13'h0, mem_addr});
		mem_stop;
		slow = 1'b1;
		base = n_cycles;
		mem_go(1'b1, 19'h00200, 8'h5a);
		wait_ready(1'b0, 10);
		wait_ready(1'b1, 100);
		mem_stop;
		tick(40);
		chk("wcount", base + 1, n_cycles);
		chk("wdata", 32'h405a, {be_seen, 6'h0, wdata_seen[7:0]});
		chk("early", 32'h0, {31'h0, early_write});
		slow = 1'b0;
	endtask : s_mem
	task automatic s_hold;
		for (int i = 0; i < 3; i++) begin
			base = n_cycles;
			{active_mode, shared_mem_enable_bit, shadow_disable_bit} = ~(3'b100 >> i);
			mem_go(1'b0, 19'h00011, 8'h00);
			tick(30);
			chk("held", 32'h0, {31'h0, host_channel_ready});
			chk("nocyc", base, n_cycles);
			{active_mode, shared_mem_enable_bit, shadow_disable_bit} = 3'h7;
			wait_ready(1'b1, 100);
			chk("latecyc", base + 1, n_cycles);
			mem_stop;
		end
	endtask : s_hold
	task automatic s_hreset;
		host_reset_mode_strap = 1'b1;
		rst_go;
		base = n_cycles;
		shared_mem_enable_bit = 1'b0;
		mem_go(1'b0, 19'h00011, 8'h00);
		for (int i = 0; i < 20 && host_reset_out_n !== 1'b0; i++) tick(1);
		chk("hrst", 32'h0, {31'h0, host_reset_out_n});
		tick(10);
		chk("hrst nocyc", base, n_cycles);
		shared_mem_enable_bit = 1'b1;
		mem_stop;
		for (int i = 0; i < 20 && host_reset_out_n !== 1'b1; i++) tick(1);
		chk("hrst end", 32'h1, {31'h0, host_reset_out_n});
		host_reset_mode_strap = 1'b0;
		shared_memory_strap_n = 1'b1;
		rst_go;
		chk("share off", 32'h0, {31'h0, shared_mem_on});
		shared_memory_strap_n = 1'b0;
		rst_go;
	endtask : s_hreset
	task automatic s_decode;
		logic [15:0] ad [7] = '{16'h60, 16'h64, 16'h62, 16'h66, 16'h70, 16'h71, 16'h170};
		logic [4:0] ex [7] = '{5'h10, 5'h11, 5'h08, 5'h09, 5'h04, 5'h05, 5'h00};
		dev_enable = 4'he;
		for (int i = 0; i < 7; i++) begin
			io(1'b0, ad[i], 8'h00);
			chk("sel", {27'h0, ex[i]}, {27'h0, dev_sel, dev_reg_sel});
			io_end;
		end
		dev_enable = 4'h0;
		io(1'b0, 16'h0070, 8'h00);
		chk("disabled", 32'h0, {28'h0, dev_sel});
		io_end;
		device_enable_strap = 1'b1;
		rst_go;
		io(1'b0, 16'h0070, 8'h00);
		chk("strap on", 32'h2, {28'h0, dev_sel});
		io_end;
		device_enable_strap = 1'b0;
		rst_go;
	endtask : s_decode
	task automatic s_cfg;
		{cfg_base_addr_high, cfg_base_addr_low} = 16'h024e;
		dev_enable = 4'h1;
		tick(3);
		io(1'b0, 16'h024e, 8'h00);
		chk("cfg invalid", 32'h0, {28'h0, dev_sel});
		io_end;
		cfg_base_valid_bit = 1'b1;
		tick(3);
		io(1'b0, 16'h024f, 8'h00);
		chk("cfg sel", 32'h3, {27'h0, dev_sel, dev_reg_sel});
		io_end;
		cfg_lock_set = 1'b1;
		tick(1);
		cfg_lock_set = 1'b0;
		{cfg_base_addr_low, cfg_base_valid_bit} = 9'h100;
		tick(3);
		chk("cfg frozen", 32'h1024e, {15'h0, cfg_valid_r, cfg_base_r});
		rst_go;
		chk("lock kept", 32'h1, {31'h0, cfg_lock_bit});
		power_up_rst = 1'b1;
		tick(2);
		power_up_rst = 1'b0;
		tick(2);
		chk("lock clr", 32'h0, {31'h0, cfg_lock_bit});
	endtask : s_cfg
	task automatic s_rtc;
		dev_enable = 4'h2;
		io(1'b1, 16'h0070, 8'h0d);
		io_end;
		chk("index", 32'h0d, {24'h0, rtc_core_index_reg});
		io(1'b0, 16'h0070, 8'h00);
		chk("host rd", 32'h10d, {23'h0, host_data_oe, host_data_out});
		io_end;
		chk("core rd blk", 32'hff, {24'h0, rtc_core_data_reg});
		core_wr(1'b0, 8'h22);
		chk("core blk", 32'h0d, {24'h0, rtc_core_index_reg});
		rtc_core_lock_bit = 1'b1;
		core_wr(1'b0, 8'h22);
		chk("core idx", 32'h22, {24'h0, rtc_core_index_reg});
		rtc_rdata = 8'h5c;
		core_wr(1'b1, 8'h99);
		chk("core data", 32'h99, {24'h0, rtc_wdata});
		chk("rtc wr", 32'h1, {31'h0, wr_seen});
		chk("core rd", 32'h5c, {24'h0, rtc_core_data_reg});
		io(1'b1, 16'h0070, 8'h33);
		io_end;
		chk("host blk", 32'h22, {24'h0, rtc_core_index_reg});
		io(1'b0, 16'h0070, 8'h00);
		chk("host rd blk", 32'h0d, {24'h0, host_data_out});
		io_end;
		rtc_unlock_request_bit = 1'b1;
		tick(1);
		chk("unlock", 32'h1, {31'h0, rtc_clear_locks});
		rtc_unlock_request_bit = 1'b0;
		rtc_core_lock_bit = 1'b0;
	endtask : s_rtc
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	// Whole sequence needs well under a thousand cycles; the ceiling leaves wide margin
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			finish_test;
		end
	end
	initial begin
		tick(2);
		rst = 1'b0;
		power_up_rst = 1'b0;
		tick(2);
		s_mem;
		s_hold;
		s_hreset;
		s_decode;
		s_cfg;
		s_rtc;
		finish_test;
	end
endmodule : host_bridge_tb
